// File: rtl/covir_pkg.sv
// constants, field layouts and carrier types for the codec output/volume/interrupt register bank
// assumes an APB slave with 32-bit data, one register per aligned word
// Functional notes
// [RQ1] out3 mute pin driven low when the mute control bit is one, high otherwise
// [RQ2] out3 source select: 001-101 analog pairs, 110 first DAC, 111 second DAC
// [RQ3] ADC levels are two's complement half-dB steps, +12 to -84 dB legal
// [RQ4] first DAC levels are unsigned half-dB attenuation, 0 to -127.5 dB
// [RQ5] second DAC levels use the same unsigned half-dB attenuation decoding
// [RQ6] DAC level changes apply per that DAC's ramp and zero-cross enables
// [RQ7] ADC level changes apply per the ADC soft ramp and zero-cross enable
// [RQ8] interrupt mode register holds four two-bit mode codes
// [RQ9] mode fields: port2 [7:6], port1 [5:4], automute [3:2], overflow [1:0]
// [RQ10] mode 00 asserts interrupt on arrival of the condition
// [RQ11] mode 01 asserts interrupt on removal of the condition
// [RQ12] mode 10 holds interrupt while condition persists; 11 reserved
// [RQ13] one automute mode code governs all four automute sources
// [RQ14] mask bits mirror status positions; one masks, zero unmasks
// [RQ15] unmasked source drives interrupt according to its group mode
// [RQ16] masked source never affects the interrupt pin
// [RQ17] overflow indicator pin always shows live ADC overflow state
// [RQ18] status bit latches one when condition occurred since last status read
// [RQ19] status read clears latched conditions and the interrupt pin
// [RQ20] reserved output control bits read zero and ignore writes
package covir_pkg;
    // register index; the bus byte address is four times the index
    localparam logic [7:0]  IDX_OUT3_CTRL  = 8'h0F;
    localparam logic [7:0]  IDX_ADC_L_VOL  = 8'h10;
    localparam logic [7:0]  IDX_ADC_R_VOL  = 8'h11;
    localparam logic [7:0]  IDX_DAC1_L_VOL = 8'h12;
    localparam logic [7:0]  IDX_DAC1_R_VOL = 8'h13;
    localparam logic [7:0]  IDX_DAC2_L_VOL = 8'h14;
    localparam logic [7:0]  IDX_DAC2_R_VOL = 8'h15;
    localparam logic [7:0]  IDX_IRQ_MODE   = 8'h16;
    localparam logic [7:0]  IDX_IRQ_MASK   = 8'h17;
    localparam logic [7:0]  IDX_IRQ_STATUS = 8'h18;
    localparam logic [7:0]  IDX_RAMP_CTRL  = 8'h19;

    localparam logic [11:0] OFF_OUT3_CTRL  = {2'h0, IDX_OUT3_CTRL, 2'h0};
    localparam logic [11:0] OFF_ADC_L_VOL  = {2'h0, IDX_ADC_L_VOL, 2'h0};
    localparam logic [11:0] OFF_ADC_R_VOL  = {2'h0, IDX_ADC_R_VOL, 2'h0};
    localparam logic [11:0] OFF_DAC1_L_VOL = {2'h0, IDX_DAC1_L_VOL, 2'h0};
    localparam logic [11:0] OFF_DAC1_R_VOL = {2'h0, IDX_DAC1_R_VOL, 2'h0};
    localparam logic [11:0] OFF_DAC2_L_VOL = {2'h0, IDX_DAC2_L_VOL, 2'h0};
    localparam logic [11:0] OFF_DAC2_R_VOL = {2'h0, IDX_DAC2_R_VOL, 2'h0};
    localparam logic [11:0] OFF_IRQ_MODE   = {2'h0, IDX_IRQ_MODE, 2'h0};
    localparam logic [11:0] OFF_IRQ_MASK   = {2'h0, IDX_IRQ_MASK, 2'h0};
    localparam logic [11:0] OFF_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
    localparam logic [11:0] OFF_RAMP_CTRL  = {2'h0, IDX_RAMP_CTRL, 2'h0};

    localparam logic [7:0] OUT3_WMASK  = 8'h0F;
    localparam int         MUTE_BIT    = 3;
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam logic [7:0] IRQ_MODE_RST = 8'hAA;   // level mode, harmless default
    localparam logic [7:0] IRQ_MASK_RST = 8'hFF;

    // status/mask bit positions
    localparam int B_D2L = 7;
    localparam int B_D2R = 6;
    localparam int B_D1L = 5;
    localparam int B_D1R = 4;
    localparam int B_SP2 = 3;
    localparam int B_SP1 = 2;
    localparam int B_OVP = 1;
    localparam int B_OVN = 0;

    // ramp control register bits
    localparam int R_D1_SOFT = 0;
    localparam int R_D1_ZC   = 1;
    localparam int R_D2_SOFT = 2;
    localparam int R_D2_ZC   = 3;
    localparam int R_ADC_SZ  = 4;
    localparam logic [7:0] RAMP_WMASK = 8'h1F;

    // legal codes run from 18h down through zero and wrap round to 58h (-84 dB)
    localparam logic [7:0] ADC_MAX = 8'h18;
    localparam logic [7:0] ADC_MIN = 8'h58;

    typedef enum logic [1:0] {
        COVIR_RISE  = 2'b00,
        COVIR_FALL  = 2'b01,
        COVIR_LEVEL = 2'b10,
        COVIR_RSVD  = 2'b11
    } covir_mode_t;

    typedef enum logic [2:0] {
        COVIR_SRC_RSVD = 3'b000,
        COVIR_SRC_AIN1 = 3'b001,
        COVIR_SRC_AIN2 = 3'b010,
        COVIR_SRC_AIN3 = 3'b011,
        COVIR_SRC_AIN4 = 3'b100,
        COVIR_SRC_AIN5 = 3'b101,
        COVIR_SRC_DAC1 = 3'b110,
        COVIR_SRC_DAC2 = 3'b111
    } covir_src_t;

    typedef struct packed {
        logic [7:0] level;
        logic       ramp_en;
        logic       zero_cross_en;
    } covir_vol_t;
endpackage

// File: rtl/covir_regs.sv
// register bank: out3 control, volumes, interrupt mode/mask/status
// assumes APB master on pclk; interrupt conditions are asynchronous pins
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module covir_regs (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // raw interrupt conditions, order as status bits
    input  wire logic [7:0]  irq_cond,
    // analog side controls
    output logic             ext_mute_out3_n,
    output covir_pkg::covir_src_t out3_source_sel,
    output logic             out3_source_valid,
    output covir_pkg::covir_vol_t adc_left_level,
    output covir_pkg::covir_vol_t adc_right_level,
    output logic [1:0]       adc_level_legal,
    output covir_pkg::covir_vol_t dac1_left_level,
    output covir_pkg::covir_vol_t dac1_right_level,
    output covir_pkg::covir_vol_t dac2_left_level,
    output covir_pkg::covir_vol_t dac2_right_level,
    // pins
    output logic             overflow_indicator_pin,
    output logic             irq_n
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic adc_legal(input logic [7:0] c);
        // -84 dB is -168 half steps, which wraps the 8-bit code; 19h..57h are reserved
        return (c <= covir_pkg::ADC_MAX) || (c >= covir_pkg::ADC_MIN);  // [RQ3]
    endfunction

    function automatic logic mode_hit(input logic [1:0] m, input logic now, input logic was);
        logic r;
        r = 1'b0;
        unique case (m)
            covir_pkg::COVIR_RISE:  r = now & ~was;  // [RQ10]
            covir_pkg::COVIR_FALL:  r = ~now & was;  // [RQ11]
            covir_pkg::COVIR_LEVEL: r = now;         // [RQ12]
            covir_pkg::COVIR_RSVD:  r = 1'b0;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] out3_reg, adc_l_reg, adc_r_reg, d1_l_reg, d1_r_reg;
    logic [7:0] d2_l_reg, d2_r_reg, mode_reg, mask_reg, status_reg, ramp_reg;
    logic [7:0] sync1_reg, sync2_reg, prev_reg;
    logic       irq_reg;
    logic       wr, rd, mapped;
    logic [7:0] rdata_next, hit, status_next;
    logic [1:0] grp_mode [8];

    assign pready  = 1'b1;
    assign wr      = psel & penable & pwrite;
    assign rd      = psel & penable & ~pwrite;
    assign pslverr = psel & penable & ~mapped;

    always_comb begin
        mapped     = 1'b1;
        rdata_next = 8'h00;
        unique case (paddr)
            covir_pkg::OFF_OUT3_CTRL:  rdata_next = out3_reg;
            covir_pkg::OFF_ADC_L_VOL:  rdata_next = adc_l_reg;
            covir_pkg::OFF_ADC_R_VOL:  rdata_next = adc_r_reg;
            covir_pkg::OFF_DAC1_L_VOL: rdata_next = d1_l_reg;
            covir_pkg::OFF_DAC1_R_VOL: rdata_next = d1_r_reg;
            covir_pkg::OFF_DAC2_L_VOL: rdata_next = d2_l_reg;
            covir_pkg::OFF_DAC2_R_VOL: rdata_next = d2_r_reg;
            covir_pkg::OFF_IRQ_MODE:   rdata_next = mode_reg;
            covir_pkg::OFF_IRQ_MASK:   rdata_next = mask_reg;
            covir_pkg::OFF_IRQ_STATUS: rdata_next = status_reg;
            covir_pkg::OFF_RAMP_CTRL:  rdata_next = ramp_reg;
            default:                   mapped = 1'b0;
        endcase
    end

    // read data is registered at the setup cycle so it stands in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, rdata_next};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out3_reg  <= covir_pkg::RESET_BYTE;
            adc_l_reg <= covir_pkg::RESET_BYTE;
            adc_r_reg <= covir_pkg::RESET_BYTE;
            d1_l_reg  <= covir_pkg::RESET_BYTE;
            d1_r_reg  <= covir_pkg::RESET_BYTE;
            d2_l_reg  <= covir_pkg::RESET_BYTE;
            d2_r_reg  <= covir_pkg::RESET_BYTE;
            mode_reg  <= covir_pkg::IRQ_MODE_RST;
            mask_reg  <= covir_pkg::IRQ_MASK_RST;
            ramp_reg  <= covir_pkg::RESET_BYTE;
        end else if (wr) begin
            unique case (paddr)
                covir_pkg::OFF_OUT3_CTRL:
                    out3_reg <= pwdata[7:0] & covir_pkg::OUT3_WMASK;  // [RQ20]
                covir_pkg::OFF_ADC_L_VOL:  adc_l_reg <= pwdata[7:0];
                covir_pkg::OFF_ADC_R_VOL:  adc_r_reg <= pwdata[7:0];
                covir_pkg::OFF_DAC1_L_VOL: d1_l_reg  <= pwdata[7:0];
                covir_pkg::OFF_DAC1_R_VOL: d1_r_reg  <= pwdata[7:0];
                covir_pkg::OFF_DAC2_L_VOL: d2_l_reg  <= pwdata[7:0];
                covir_pkg::OFF_DAC2_R_VOL: d2_r_reg  <= pwdata[7:0];
                covir_pkg::OFF_IRQ_MODE:   mode_reg  <= pwdata[7:0];  // [RQ8]
                covir_pkg::OFF_IRQ_MASK:   mask_reg  <= pwdata[7:0];  // [RQ14]
                covir_pkg::OFF_RAMP_CTRL:
                    ramp_reg <= pwdata[7:0] & covir_pkg::RAMP_WMASK;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs toward the analog and volume engines
    assign ext_mute_out3_n   = ~out3_reg[covir_pkg::MUTE_BIT];  // [RQ1]
    assign out3_source_sel   = covir_pkg::covir_src_t'(out3_reg[2:0]);  // [RQ2]
    assign out3_source_valid = (out3_reg[2:0] != covir_pkg::COVIR_SRC_RSVD);  // [RQ2]
    assign adc_level_legal   = {adc_legal(adc_r_reg), adc_legal(adc_l_reg)};  // [RQ3]

    // the volume engines do the ramping; here only the enables travel with the level
    assign adc_left_level  = '{adc_l_reg, ramp_reg[covir_pkg::R_ADC_SZ],
                               ramp_reg[covir_pkg::R_ADC_SZ]};  // [RQ7]
    assign adc_right_level = '{adc_r_reg, ramp_reg[covir_pkg::R_ADC_SZ],
                               ramp_reg[covir_pkg::R_ADC_SZ]};  // [RQ7]
    assign dac1_left_level  = '{d1_l_reg, ramp_reg[covir_pkg::R_D1_SOFT],
                                ramp_reg[covir_pkg::R_D1_ZC]};  // [RQ4] [RQ6]
    assign dac1_right_level = '{d1_r_reg, ramp_reg[covir_pkg::R_D1_SOFT],
                                ramp_reg[covir_pkg::R_D1_ZC]};  // [RQ4] [RQ6]
    assign dac2_left_level  = '{d2_l_reg, ramp_reg[covir_pkg::R_D2_SOFT],
                                ramp_reg[covir_pkg::R_D2_ZC]};  // [RQ5] [RQ6]
    assign dac2_right_level = '{d2_r_reg, ramp_reg[covir_pkg::R_D2_SOFT],
                                ramp_reg[covir_pkg::R_D2_ZC]};  // [RQ5] [RQ6]

    ////////////////////////////////////////////////////////////////////////
    // condition pins come from other clock domains
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
            prev_reg  <= 8'h00;
        end else begin
            sync1_reg <= irq_cond;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    assign overflow_indicator_pin = sync2_reg[covir_pkg::B_OVP] |
                                    sync2_reg[covir_pkg::B_OVN];  // [RQ17]

    always_comb begin
        grp_mode[covir_pkg::B_D2L] = mode_reg[3:2];  // [RQ9] [RQ13]
        grp_mode[covir_pkg::B_D2R] = mode_reg[3:2];
        grp_mode[covir_pkg::B_D1L] = mode_reg[3:2];
        grp_mode[covir_pkg::B_D1R] = mode_reg[3:2];
        grp_mode[covir_pkg::B_SP2] = mode_reg[7:6];  // [RQ9]
        grp_mode[covir_pkg::B_SP1] = mode_reg[5:4];  // [RQ9]
        grp_mode[covir_pkg::B_OVP] = mode_reg[1:0];  // [RQ9]
        grp_mode[covir_pkg::B_OVN] = mode_reg[1:0];
        for (int i = 0; i < 8; i++) begin
            hit[i] = mode_hit(grp_mode[i], sync2_reg[i], prev_reg[i]);  // [RQ15]
        end
    end

    // a new hit in the read cycle survives the clear
    always_comb begin
        status_next = status_reg;
        if (rd && paddr == covir_pkg::OFF_IRQ_STATUS) begin
            status_next = 8'h00;  // [RQ19]
        end
        status_next = status_next | hit;  // [RQ18]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= 8'h00;
        end else begin
            status_reg <= status_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_next & ~mask_reg);  // [RQ14] [RQ16] [RQ19]
        end
    end

    assign irq_n = ~irq_reg;

endmodule // covir_regs

// File: sim/covir_regs_checker.sv
// checker: concurrent properties on the register bank ports
// assumes it is bound onto covir_regs, one clock and one reset
`timescale 1ns/1ps
module covir_regs_checker (
    // apb
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    // pins and controls
    input wire logic [7:0]            irq_cond,
    input wire logic                  ext_mute_out3_n,
    input wire covir_pkg::covir_src_t out3_source_sel,
    input wire logic                  out3_source_valid,
    input wire covir_pkg::covir_vol_t dac1_left_level,
    input wire logic                  overflow_indicator_pin,
    input wire logic                  irq_n
);
    logic       wr;
    logic       rd;
    logic [7:0] mask_copy;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    // shadow mask, so the quiet-pin check knows when every source is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            mask_copy <= covir_pkg::IRQ_MASK_RST;
        else if (wr && paddr == covir_pkg::OFF_IRQ_MASK)
            mask_copy <= pwdata[7:0];
    end
    ////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_mute_pin_level: assert property (wr && paddr == covir_pkg::OFF_OUT3_CTRL
        |=> ext_mute_out3_n == !$past(pwdata[3])) else $error("mute pin wrong");
    a_source_write: assert property (wr && paddr == covir_pkg::OFF_OUT3_CTRL
        |=> out3_source_sel == $past(pwdata[2:0])) else $error("source select wrong");
    a_source_valid: assert property (wr && paddr == covir_pkg::OFF_OUT3_CTRL
        |=> out3_source_valid == ($past(pwdata[2:0]) != 3'h0))
        else $error("source valid wrong");
    a_dac_level: assert property (wr && paddr == covir_pkg::OFF_DAC1_L_VOL
        |=> dac1_left_level.level == $past(pwdata[7:0])) else $error("dac level wrong");
    a_out3_reserved: assert property (rd && paddr == covir_pkg::OFF_OUT3_CTRL
        |-> prdata[7:4] == 4'h0) else $error("reserved bits set");
    a_clip_pin_live: assert property ($stable(irq_cond[1:0]) [*4]
        |-> overflow_indicator_pin == |irq_cond[1:0]) else $error("clip pin wrong");
    a_masked_quiet: assert property (mask_copy == 8'hFF && $past(mask_copy) == 8'hFF
        |-> irq_n) else $error("masked irq active");
    a_read_clears: assert property ((irq_cond == 8'h00) [*6] ##0
        (rd && paddr == covir_pkg::OFF_IRQ_STATUS) |-> ##[1:2] irq_n)
        else $error("irq not cleared");
endmodule // covir_regs_checker

bind covir_regs covir_regs_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .irq_cond, .ext_mute_out3_n, .out3_source_sel,
    .out3_source_valid, .dac1_left_level, .overflow_indicator_pin, .irq_n);

// File: sim/tb.sv
// tb: self-checking apb bench for the register bank
// assumes a zero-wait slave and condition levels driven straight from here
`timescale 1ns/1ps
module tb;
    logic                  pclk = 1'b0;
    logic                  presetn = 1'b0;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [11:0]           paddr = 12'h000;
    logic [31:0]           pwdata = 32'h0;
    logic [7:0]            irq_cond = 8'h00;
    logic [31:0]           prdata, r;
    logic                  pready, pslverr, serr, mute_n, src_ok, ovf, irq_n;
    covir_pkg::covir_src_t src;
    covir_pkg::covir_vol_t adc_l, adc_r, d1_l, d1_r, d2_l, d2_r;
    logic [1:0]            adc_ok;
    int                    errors = 0;
    int                    num_checks = 0;
    int                    i, m;
    always #4 pclk = ~pclk;
    covir_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .pslverr, .prdata, .irq_cond, .ext_mute_out3_n(mute_n), .out3_source_sel(src),
        .out3_source_valid(src_ok), .adc_left_level(adc_l), .adc_right_level(adc_r),
        .adc_level_legal(adc_ok), .dac1_left_level(d1_l), .dac1_right_level(d1_r),
        .dac2_left_level(d2_l), .dac2_right_level(d2_r),
        .overflow_indicator_pin(ovf), .irq_n);
    ////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    task automatic wait6;
        repeat (6) @(posedge pclk);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(covir_pkg::OFF_IRQ_MODE, 32'hAA);
        rd(covir_pkg::OFF_IRQ_MASK, 32'hFF);
        apb(1'b1, covir_pkg::OFF_OUT3_CTRL, 32'hFF);
        rd(covir_pkg::OFF_OUT3_CTRL, 32'h0F);
        chk({mute_n, src_ok, src}, 32'h0F);
        apb(1'b1, covir_pkg::OFF_OUT3_CTRL, 32'h06);
        chk({mute_n, src_ok, src}, 32'h1E);
        apb(1'b1, covir_pkg::OFF_OUT3_CTRL, 32'h00);
        chk({mute_n, src_ok, src}, 32'h10);
        $display("test out3 done");
        for (i = 0; i < 6; i++)
            apb(1'b1, covir_pkg::OFF_ADC_L_VOL + 12'(4 * i), 32'hF8 + i);
        for (i = 0; i < 6; i++)
            rd(covir_pkg::OFF_ADC_L_VOL + 12'(4 * i), 32'hF8 + i);
        chk(d2_r.level, 32'hFD);
        chk({adc_l.level, adc_r.level, d1_r.level, d2_l.level}, 32'hF8F9FBFC);
        chk(adc_ok, 32'h3);
        apb(1'b1, covir_pkg::OFF_ADC_R_VOL, 32'h57);
        chk(adc_ok, 32'h1);
        apb(1'b1, covir_pkg::OFF_ADC_L_VOL, 32'h19);
        chk(adc_ok, 32'h0);
        apb(1'b1, covir_pkg::OFF_ADC_R_VOL, 32'h18);
        apb(1'b1, covir_pkg::OFF_ADC_L_VOL, 32'h58);
        chk(adc_ok, 32'h3);
        apb(1'b1, covir_pkg::OFF_DAC1_L_VOL, 32'hFF);
        chk(d1_l.level, 32'hFF);
        for (m = 5; m < 32; m += 21) begin
            apb(1'b1, covir_pkg::OFF_RAMP_CTRL, 32'hE0 | m);
            rd(covir_pkg::OFF_RAMP_CTRL, m);
            chk({adc_l.ramp_en, d2_l.zero_cross_en, d2_l.ramp_en, d1_l.zero_cross_en,
                d1_l.ramp_en}, m);
            chk(adc_r.zero_cross_en, m >> 4);
        end
        $display("test levels done");
        apb(1'b1, covir_pkg::OFF_IRQ_MASK, 32'h00);
        // port1 group through rise, fall and level; other groups parked on 11
        for (m = 0; m < 3; m++) begin
            apb(1'b1, covir_pkg::OFF_IRQ_MODE, 32'hCF | (m << 4));
            irq_cond[2] <= 1'b1;
            wait6;
            chk(irq_n, m == 1);
            irq_cond[2] <= 1'b0;
            wait6;
            chk(irq_n, 0);
            rd(covir_pkg::OFF_IRQ_STATUS, 32'h04);
            repeat (2) @(posedge pclk);
            chk(irq_n, 1);
        end
        apb(1'b1, covir_pkg::OFF_IRQ_MODE, 32'hF3);
        for (i = 4; i < 8; i++) begin
            irq_cond[i] <= 1'b1;
            wait6;
            chk(irq_n, 0);
            irq_cond[i] <= 1'b0;
            wait6;
            rd(covir_pkg::OFF_IRQ_STATUS, 32'h1 << i);
        end
        $display("test interrupt modes done");
        apb(1'b1, covir_pkg::OFF_IRQ_MASK, 32'h02);
        apb(1'b1, covir_pkg::OFF_IRQ_MODE, 32'hFC);
        irq_cond <= 8'h02;
        wait6;
        chk({irq_n, ovf}, 32'h3);
        irq_cond <= 8'h00;
        wait6;
        chk(ovf, 0);
        rd(covir_pkg::OFF_IRQ_STATUS, 32'h02);
        apb(1'b0, 12'h100, 32'h0);
        chk(r, 32'h0);
        chk(serr, 1);
        $display("test mask done");
        wrap_up;
    end
    initial begin
        #(8 * 5000);
        errors++;
        wrap_up;
    end
endmodule // tb
